// File: common/shv_consts.vh
`ifndef SHV_CONSTS_VH
`define SHV_CONSTS_VH

// Register index (double-word address on the low address lines) of the interrupt status register
`define SHV_INT_STATUS_INDEX 7'h05
// Cycles a host external access waits, less one, before ready is given
`define SHV_EXT_WAIT 4'h3
// Own video RAM cycle kinds
`define SHV_KIND_DATA 2'h0
`define SHV_KIND_TRANSFER 2'h1
`define SHV_KIND_REFRESH 2'h2
// Byte enable that selects the register half word
`define SHV_HALF_SEL_BIT 0
// Enable pattern that turns all four bytes on (active low)
`define SHV_BE_ALL_N 4'h0
`define SHV_BE_NONE_N 4'hF

`endif

// File: design/shv_host_vram_bus.v
`timescale 1ns/1ps
`default_nettype none
`include "shv_consts.vh"

module shv_host_vram_bus (
   // Clock and reset
   input wire clk_sys,
   input wire resetn,
   // Host handshake
   input wire hostAccessRequestN,
   input wire hostAddrValidN,
   input wire hostRegselN,
   input wire hostMemselN,
   output reg hostBusGrantN,
   output reg hostXferReadyN,
   output reg hostIrqN,
   // Shared address bus, bits 31..2
   input wire [6:0] addrLoIn,
   output reg [29:0] addrOut,
   output reg addrOe,
   // Shared data bus
   input wire [31:0] dataIn,
   output reg [31:0] dataOut,
   output reg dataOe,
   // Shared byte enables, active low
   input wire [3:0] byteEnN_in,
   output reg [3:0] byteEnN_out,
   output reg byteEnOe,
   // Shared write enable, active low
   input wire writeEnN_in,
   output reg writeEnN_out,
   output reg writeEnOe,
   // Own memory cycle definition and ready
   input wire memReadyN,
   output reg memCycleStartN,
   output reg memTransferCycleN,
   output reg memRefreshCycleN,
   output reg clockOutput,
   // Core side memory request, held until acknowledged
   input wire coreReq,
   input wire coreWrite,
   input wire [1:0] coreKind,
   input wire [29:0] coreAddr,
   input wire [3:0] coreByteEn,
   input wire [31:0] coreWdata,
   output reg coreAck,
   output reg [31:0] coreRdata,
   // Internal register file side
   input wire [15:0] regRdata,
   output reg regStrobe,
   output reg regWrite,
   output reg [6:0] regIndex,
   output reg regOddWord,
   output reg [15:0] regWdata,
   // Interrupt sources
   input wire irqEvent,
   input wire irqEnable
);

   // ==========================================================
   // States
   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_GRANT = 4'h1;
   localparam [3:0] ST_REGR = 4'h2;
   localparam [3:0] ST_HMEM = 4'h3;
   localparam [3:0] ST_HEXT = 4'h4;
   localparam [3:0] ST_DONE = 4'h5;
   localparam [3:0] ST_MEMT1 = 4'h6;
   localparam [3:0] ST_MEMW = 4'h7;
   localparam [3:0] ST_REGW = 4'h8;

   reg [3:0] state_q;
   reg [3:0] extCnt_q;
   reg ownWrite_q;
   wire hostReqN;
   wire hostValidN;
   wire irqSet;
   wire statusRead;

   // ==========================================================
   // Asynchronous host strobes
   shv_sync3 #(.INIT(1'b1)) uSyncReq (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .asyncIn(hostAccessRequestN),
      .syncOut(hostReqN)
   );

   shv_sync3 #(.INIT(1'b1)) uSyncValid (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .asyncIn(hostAddrValidN),
      .syncOut(hostValidN)
   );

   // ==========================================================
   // Clock output: half rate toggle gives an exact 50% duty
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         clockOutput <= 1'b0;
      end else begin
         clockOutput <= ~clockOutput;
      end
   end

   // ==========================================================
   // Interrupt: a set in the clearing cycle wins
   assign irqSet = irqEvent & irqEnable;
   assign statusRead = regStrobe & ~regWrite & (regIndex == `SHV_INT_STATUS_INDEX);

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         hostIrqN <= 1'b1;
      end else if (irqSet) begin
         hostIrqN <= 1'b0;
      end else if (statusRead) begin
         hostIrqN <= 1'b1;
      end
   end

   // ==========================================================
   // Access sequencer
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         extCnt_q <= 4'h0;
         ownWrite_q <= 1'b0;
         hostBusGrantN <= 1'b1;
         hostXferReadyN <= 1'b1;
         addrOut <= 30'h0;
         addrOe <= 1'b0;
         dataOut <= 32'h0;
         dataOe <= 1'b0;
         byteEnN_out <= `SHV_BE_NONE_N;
         byteEnOe <= 1'b0;
         writeEnN_out <= 1'b1;
         writeEnOe <= 1'b0;
         memCycleStartN <= 1'b1;
         memTransferCycleN <= 1'b1;
         memRefreshCycleN <= 1'b1;
         coreAck <= 1'b0;
         coreRdata <= 32'h0;
         regStrobe <= 1'b0;
         regWrite <= 1'b0;
         regIndex <= 7'h0;
         regOddWord <= 1'b0;
         regWdata <= 16'h0;
      end else begin
         coreAck <= 1'b0;
         regStrobe <= 1'b0;
         memCycleStartN <= 1'b1;
         case (state_q)
            ST_IDLE: begin
               // Host is served ahead of the core's own cycles
               if (!hostReqN) begin
                  hostBusGrantN <= 1'b0;
                  addrOe <= 1'b0;
                  dataOe <= 1'b0;
                  byteEnOe <= 1'b0;
                  writeEnOe <= 1'b0;
                  state_q <= ST_GRANT;
               end else if (coreReq) begin
                  ownWrite_q <= coreWrite;
                  addrOut <= coreAddr;
                  addrOe <= 1'b1;
                  dataOut <= coreWdata;
                  dataOe <= coreWrite;
                  // Reads fetch the whole double word
                  byteEnN_out <= coreWrite ? ~coreByteEn : `SHV_BE_ALL_N;
                  byteEnOe <= 1'b1;
                  writeEnN_out <= ~coreWrite;
                  writeEnOe <= 1'b1;
                  memCycleStartN <= 1'b0;
                  memTransferCycleN <= ~(coreKind == `SHV_KIND_TRANSFER);
                  memRefreshCycleN <= ~(coreKind == `SHV_KIND_REFRESH);
                  state_q <= ST_MEMT1;
               end
            end
            ST_MEMT1: begin
               state_q <= ST_MEMW;
            end
            ST_MEMW: begin
               // Cycle definition holds until memory is ready
               if (!memReadyN) begin
                  if (!ownWrite_q) begin
                     coreRdata <= dataIn;
                  end
                  coreAck <= 1'b1;
                  memTransferCycleN <= 1'b1;
                  memRefreshCycleN <= 1'b1;
                  addrOe <= 1'b0;
                  dataOe <= 1'b0;
                  byteEnOe <= 1'b0;
                  writeEnOe <= 1'b0;
                  writeEnN_out <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            ST_GRANT: begin
               // Host selects decide the access kind
               if (!hostValidN) begin
                  regIndex <= addrLoIn;
                  regOddWord <= byteEnN_in[`SHV_HALF_SEL_BIT];
                  regWrite <= ~writeEnN_in;
                  extCnt_q <= 4'h0;
                  if (!hostRegselN) begin
                     if (!writeEnN_in) begin
                        hostXferReadyN <= 1'b0;
                        state_q <= ST_REGW;
                     end else begin
                        regStrobe <= 1'b1;
                        state_q <= ST_REGR;
                     end
                  end else if (!hostMemselN) begin
                     state_q <= ST_HMEM;
                  end else begin
                     state_q <= ST_HEXT;
                  end
               end else if (hostReqN) begin
                  hostBusGrantN <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            ST_REGW: begin
               // Host data is valid while ready is shown
               regWdata <= regOddWord ? dataIn[15:0] : dataIn[31:16];
               regStrobe <= 1'b1;
               state_q <= ST_DONE;
            end
            ST_REGR: begin
               // Unused half word is driven as zero
               dataOut <= regOddWord ? {16'h0, regRdata} : {regRdata, 16'h0};
               dataOe <= 1'b1;
               hostXferReadyN <= 1'b0;
               state_q <= ST_DONE;
            end
            ST_HMEM: begin
               // Host owns data and write enable; memory ready closes it
               if (!memReadyN) begin
                  hostXferReadyN <= 1'b0;
                  state_q <= ST_DONE;
               end
            end
            ST_HEXT: begin
               if (extCnt_q == `SHV_EXT_WAIT) begin
                  hostXferReadyN <= 1'b0;
                  state_q <= ST_DONE;
               end else begin
                  extCnt_q <= extCnt_q + 4'h1;
               end
            end
            ST_DONE: begin
               // Ready holds until the host drops its request
               if (hostReqN) begin
                  hostXferReadyN <= 1'b1;
                  hostBusGrantN <= 1'b1;
                  dataOe <= 1'b0;
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // shv_host_vram_bus

`default_nettype wire

// File: design/shv_sync3.v
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; the output follows only once stages two and three agree
module shv_sync3 #(
   parameter INIT = 1'b1
) (
   // Clock and reset
   input wire clk_sys,
   input wire resetn,
   // Asynchronous level in, synchronised level out
   input wire asyncIn,
   output reg syncOut
);

   reg s1_q;
   reg s2_q;
   reg s3_q;

   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         syncOut <= INIT;
      end else begin
         s1_q <= asyncIn;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            syncOut <= s3_q;
         end
      end
   end

endmodule // shv_sync3

`default_nettype wire

// File: testbench/shv_host_vram_bus_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "shv_consts.vh"
// ====
// Port checker
module shv_host_vram_bus_assertions (
   // Handshake, float and cycle outputs
   input wire logic clk_sys, resetn, hostBusGrantN, hostXferReadyN, hostIrqN, hostMemselN,
   input wire logic addrOe, dataOe, byteEnOe, writeEnOe, writeEnN_out, clockOutput,
   input wire logic memCycleStartN, memTransferCycleN, memRefreshCycleN, coreAck,
   input wire logic regStrobe, regWrite, irqEvent, irqEnable,
   input wire logic [3:0] byteEnN_out,
   input wire logic [6:0] regIndex
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   wire statRd = regStrobe && !regWrite && regIndex == `SHV_INT_STATUS_INDEX;
   wire irqSet = irqEvent && irqEnable;
   property p_start; !memCycleStartN |=> memCycleStartN; endproperty
   a_start: assert property (p_start) else $error("start too long");
   property p_defs; $fell(memTransferCycleN) || $fell(memRefreshCycleN) |-> !memCycleStartN;
   endproperty
   a_defs: assert property (p_defs) else $error("definition late");
   property p_hold; !memTransferCycleN && !coreAck |=> !memTransferCycleN || coreAck;
   endproperty
   a_hold: assert property (p_hold) else $error("transfer dropped");
   property p_rdAll; !memCycleStartN && writeEnN_out |-> byteEnN_out == `SHV_BE_ALL_N;
   endproperty
   a_rdAll: assert property (p_rdAll) else $error("read enables");
   property p_kind; !memCycleStartN |-> writeEnOe && (memTransferCycleN || memRefreshCycleN);
   endproperty
   a_kind: assert property (p_kind) else $error("cycle kind");
   property p_float; !hostBusGrantN |-> !addrOe && !byteEnOe && !writeEnOe; endproperty
   a_float: assert property (p_float) else $error("not floated");
   property p_memD; !hostXferReadyN && !hostMemselN |-> !dataOe; endproperty
   a_memD: assert property (p_memD) else $error("data driven");
   property p_rdy; !hostXferReadyN |-> !hostBusGrantN; endproperty
   a_rdy: assert property (p_rdy) else $error("ready outside access");
   property p_irq; irqSet |=> !hostIrqN; endproperty
   a_irq: assert property (p_irq) else $error("irq missed");
   property p_irqHold; !hostIrqN && !statRd |=> !hostIrqN; endproperty
   a_irqHold: assert property (p_irqHold) else $error("irq dropped");
   property p_irqClr; statRd && !irqSet |=> hostIrqN; endproperty
   a_irqClr: assert property (p_irqClr) else $error("irq kept");
   property p_clk; clockOutput |=> !clockOutput; endproperty
   a_clk: assert property (p_clk) else $error("clock high twice");
   property p_clkLo; !clockOutput |=> clockOutput; endproperty
   a_clkLo: assert property (p_clkLo) else $error("clock low twice");
endmodule // shv_host_vram_bus_assertions
bind shv_host_vram_bus shv_host_vram_bus_assertions shv_host_vram_bus_assertions_i (.*);
`default_nettype wire

// File: testbench/shv_host_vram_bus_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "shv_consts.vh"
module shv_host_vram_bus_bench;
   typedef struct packed {logic [1:0] kind; logic wr; logic [3:0] be; logic [31:0] d;
      logic [1:0] trRf;} shv_row_t;
   logic clk_sys = 0, resetn = 0, hostAccessRequestN = 1, hostAddrValidN = 1;
   logic hostRegselN = 1, hostMemselN = 1, coreReq = 0, coreWrite = 0, irqPulse = 0;
   logic irqEnable = 0, armSame = 0, hDrv = 0, hWe = 1, hGo = 0;
   logic [1:0] coreKind = 0;
   logic [29:0] coreAddr = 30'h1;
   logic [3:0] coreByteEn = 0, hBe = 4'hF;
   logic [31:0] coreWdata = 0, hData = 0, shadow = 0;
   logic [6:0] hIx = 0;
   logic [15:0] regRdata = 16'h5A3C;
   wire hostBusGrantN, hostXferReadyN, hostIrqN, addrOe, dataOe, byteEnOe, writeEnN_out;
   wire writeEnOe, memReadyN, memCycleStartN, memTransferCycleN, memRefreshCycleN;
   wire clockOutput, coreAck, regStrobe, regWrite, regOddWord;
   wire [29:0] addrOut;
   wire [31:0] dataOut, coreRdata, vData;
   wire [3:0] byteEnN_out;
   wire [6:0] regIndex;
   wire [15:0] regWdata;
   wire irqEvent = irqPulse | (armSame & regStrobe);
   wire [31:0] dataBus = dataOe ? dataOut : hDrv ? hData : vData;
   wire [3:0] beBus = byteEnOe ? byteEnN_out : hBe;
   wire weBus = writeEnOe ? writeEnN_out : hWe;
   wire [6:0] aLo = addrOe ? addrOut[6:0] : hIx;
   int fails = 0, testsRun = 0, i, k, b;
   shv_row_t r;
   shv_row_t rows [6] = '{'{1, 0, 0, 0, 1}, '{2, 0, 0, 0, 2}, '{0, 1, 4'hF, 32'h11223344, 3},
      '{0, 1, 4'h5, 32'hAABBCCDD, 3}, '{0, 1, 4'h8, 32'h99000000, 3}, '{0, 0, 4'h1, 0, 3}};
   shv_host_vram_bus shv_host_vram_bus_i (.*, .addrLoIn(aLo), .dataIn(dataBus),
      .byteEnN_in(beBus), .writeEnN_in(weBus));
   shv_vram_model shv_vram_model_i (.clk_sys, .resetn, .startN(memCycleStartN), .ack(coreAck),
      .hostGo(hGo), .weN(weBus), .addr(aLo[3:0]), .beN(beBus), .wdata(dataBus),
      .readyN(memReadyN), .rdata(vData));
   always #5 clk_sys = ~clk_sys;
   task chk(input string n, input logic [47:0] s, e);
      testsRun++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", testsRun, fails);
      if (fails == 0 && testsRun > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Host lines are driven only once the grant is seen
   task host(input logic rN, mN, wN, input logic [3:0] be, input logic [6:0] ix,
      input logic [31:0] d);
      @(negedge clk_sys) hostAccessRequestN = 0;
      for (k = 0; k < 20 && hostBusGrantN !== 1'b0; k++) @(negedge clk_sys);
      {hostRegselN, hostMemselN, hWe, hBe, hIx, hData} = {rN, mN, wN, be, ix, d};
      {hDrv, hGo, hostAddrValidN} = {!wN, !mN, 1'b0};
      for (k = 0; k < 30 && hostXferReadyN !== 1'b0; k++) @(negedge clk_sys);
      chk("ready", hostXferReadyN, 0);
   endtask
   task hostEnd;
      @(negedge clk_sys) {hostAccessRequestN, hostAddrValidN, hDrv, hGo} = 4'hC;
      for (k = 0; k < 20 && hostBusGrantN !== 1'b1; k++) @(negedge clk_sys);
      chk("release", {hostBusGrantN, hostXferReadyN, dataOe}, 3'h6);
   endtask
   initial begin
      #100000 fails++;
      end_of_test;
   end
   initial begin
      repeat (2) @(negedge clk_sys);
      chk("rst", {hostBusGrantN, hostXferReadyN, hostIrqN, memCycleStartN, addrOe, dataOe}, 6'h3C);
      resetn = 1;
      for (i = 0; i < 6; i++) begin
         r = rows[i];
         @(negedge clk_sys) {coreReq, coreKind, coreWrite, coreByteEn, coreWdata} = {1'b1, r[40:2]};
         for (k = 0; k < 20 && memCycleStartN !== 1'b0; k++) @(negedge clk_sys);
         chk("defs", {memTransferCycleN, memRefreshCycleN}, r.trRf);
         chk("we", writeEnN_out, !r.wr);
         chk("be", byteEnN_out, r.wr ? 4'(~r.be) : 4'h0);
         chk("addr", addrOut, 30'h1);
         @(negedge clk_sys);
         chk("pulse", memCycleStartN, 1);
         chk("hold", {memTransferCycleN, memRefreshCycleN}, r.trRf);
         for (k = 0; k < 20 && coreAck !== 1'b1; k++) @(negedge clk_sys);
         coreReq = 0;
         if (!r.wr && r.kind == 0) chk("rdata", coreRdata, shadow);
         for (b = 0; b < 4; b++) if (r.wr && r.be[b]) shadow[8*b+:8] = r.d[8*b+:8];
      end
      for (b = 0; b < 2; b++) begin
         host(0, 1, 0, {3'h7, b[0]}, 7'h03, 32'h1234ABCD);
         @(negedge clk_sys);
         chk("regWr", {regStrobe, regWrite, regIndex}, {2'h3, 7'h03});
         chk("odd", regOddWord, b[0]);
         chk("half", regWdata, b ? 16'hABCD : 16'h1234);
         hostEnd;
         host(0, 1, 1, {3'h7, b[0]}, 7'h03, 0);
         chk("rdOe", dataOe, 1);
         chk("regRd", dataOut, b ? {16'h0, regRdata} : {regRdata, 16'h0});
         hostEnd;
      end
      @(negedge clk_sys) irqPulse = 1;
      @(negedge clk_sys) chk("mask", hostIrqN, 1);
      irqEnable = 1;
      @(negedge clk_sys) chk("irq", hostIrqN, 0);
      irqPulse = 0;
      for (b = 0; b < 2; b++) begin
         armSame = b[0];
         host(0, 1, 1, 4'hF, `SHV_INT_STATUS_INDEX, 0);
         hostEnd;
         chk("irqRd", hostIrqN, !b[0]);
      end
      armSame = 0;
      host(1, 0, 0, 4'h0, 7'h02, 32'hCAFE0001);
      chk("memFloat", {dataOe, writeEnOe}, 0);
      chk("memWr", shv_vram_model_i.mem[2], 32'hCAFE0001);
      hostEnd;
      host(1, 1, 0, 4'hF, 7'h00, 0);
      chk("extFloat", writeEnOe, 0);
      hostEnd;
      chk("irqHeld", hostIrqN, 0);
      // Mid-run reset with an interrupt pending: grant, ready, interrupt and clock outputs return to rest
      resetn = 0;
      @(negedge clk_sys);
      chk("rst2", {hostBusGrantN, hostXferReadyN, hostIrqN, clockOutput}, 4'hE);
      resetn = 1;
      @(negedge clk_sys) chk("rel", {hostBusGrantN, hostIrqN, clockOutput}, 3'h7);
      end_of_test;
   end
endmodule // shv_host_vram_bus_bench
`default_nettype wire

// File: testbench/shv_vram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Shared video RAM; ready after WAIT cycles, held until the cycle ends
module shv_vram_model #(
   parameter int WAIT = 2
) (
   input wire logic clk_sys, resetn, startN, ack, hostGo, weN,
   input wire logic [3:0] addr, beN,
   input wire logic [31:0] wdata,
   output logic readyN,
   output logic [31:0] rdata
);
   logic [31:0] mem [16];
   logic [31:0] lastQ;
   logic ownQ;
   int cnt;
   wire act = ownQ || hostGo;
   assign readyN = !(act && cnt == 0);
   // Released bus shows a toggling pattern, never the last value
   assign rdata = readyN ? ~lastQ : mem[addr];
   initial for (int i = 0; i < 16; i++) mem[i] = 32'h0;
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ownQ <= 1'b0;
         cnt <= WAIT;
         lastQ <= 32'h0;
      end else begin
         ownQ <= !startN || (ownQ && !ack);
         cnt <= act ? (cnt > 0 ? cnt - 1 : 0) : WAIT;
         lastQ <= rdata;
         // Disabled lanes keep their old contents
         for (int b = 0; b < 4; b++) begin
            if (!readyN && !weN && !beN[b]) begin
               mem[addr][8*b+:8] <= wdata[8*b+:8];
            end
         end
      end
   end
endmodule // shv_vram_model
`default_nettype wire
